/* File: rtl/ddl_pkg.sv */
// package for the dual channel serial load control block
// assumes a system clock mclk and a separate serial link clock
`default_nettype none
package ddl_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CODE_BITS = 16;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] CNT_LAST = 5'h18;
   localparam logic [4:0] CNT_ABORT = 5'h17;
   // frame layout: [23:20] command, [19:16] address, [15:0] data
   localparam int CMD_HI = 23;
   localparam int CMD_LO = 20;
   localparam int ADR_HI = 19;
   localparam int ADR_LO = 16;
   localparam logic [3:0] CMD_WR_BUF = 4'h0;
   localparam logic [3:0] CMD_WR_UPD = 4'h3;
   localparam logic [3:0] ADR_A = 4'h0;
   localparam logic [3:0] ADR_B = 4'h1;
   localparam logic [3:0] ADR_ALL = 4'h7;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam int SCLK_MAX_MHZ = 50;
endpackage : ddl_pkg
`default_nettype wire

/* File: rtl/ddl_link_rx.sv */
// serial shift front end, clocked by the falling edge of the link clock
// assumes frame select is synchronous to the link clock from the host
`default_nettype none
module ddl_link_rx
(
   // link side
   input  wire logic        sclk,
   input  wire logic        frameSel_n,
   input  wire logic        sdin,
   // frame out, done level
   output logic [23:0]      frameWord,
   output logic             frameDone
);
   typedef struct packed
   {
      logic [23:0] shift;
      logic [23:0] word;
      logic        done;
   } ddl_rx_t;
   ddl_rx_t    rx_ff, nxt_rx;
   // count kept apart: it alone needs the asynchronous clear
   logic [4:0] cnt_ff, nxt_cnt;

   // count and shift; done falls at the first edge of the next frame
   always_comb
   begin
      nxt_rx = rx_ff;
      nxt_cnt = cnt_ff;
      if (cnt_ff != ddl_pkg::CNT_LAST)         // [R14]
      begin
         nxt_rx.shift = {rx_ff.shift[ddl_pkg::FRAME_BITS-2:0], sdin}; // [R02]
         nxt_cnt = cnt_ff + 5'h01;             // [R01]
         nxt_rx.done = (cnt_ff == ddl_pkg::CNT_ABORT); // [R03]
         if (cnt_ff == ddl_pkg::CNT_ABORT)
         begin
            nxt_rx.word = {rx_ff.shift[ddl_pkg::FRAME_BITS-2:0], sdin};
         end
      end
   end

   // frame select high clears the count at once, so a short frame dies
   always_ff @(negedge sclk or posedge frameSel_n)
   begin
      if (frameSel_n)
         cnt_ff <= '0;                          // [R04]
      else
         cnt_ff <= nxt_cnt;
   end

   // done stays high between frames, long enough for the mclk side
   always_ff @(negedge sclk)
   begin
      rx_ff <= nxt_rx;
   end

   assign frameWord = rx_ff.word;
   assign frameDone = rx_ff.done;
endmodule : ddl_link_rx
`default_nettype wire

/* File: rtl/ddl_load_ctrl.sv */
// dual channel load control: buffers, outputs, load and clear handling
// assumes pins arrive asynchronous to mclk; the link runs on sclk
`default_nettype none
// Operation
// [R01] frame select low enables shifting on falling shift clock edges
// [R02] twenty-four bit shift register, one bit per falling edge
// [R03] frame acts only after its 24th falling edge
// [R04] frame select high before edge 24 discards the partial frame
// [R05] host keeps shift clock at or below 50 MHz; the bench host model clocks it at a 15 ns period, about 66.7 MHz
// [R06] synchronous mode updates output at the 24th edge
// [R07] host holds load pin low for synchronous updates
// [R08] load pin falling edge copies both buffers to outputs together
// [R09] several buffer writes, then one load edge updates outputs
// [R10] clear pin falling edge loads reset code into all registers
// [R11] clear-code mode holds until the 24th edge of next write
// [R12] clear during a frame aborts that write
// [R13] separate buffer and output register per channel
// [R14] extra clock edges after the 24th are ignored until reselect
module ddl_load_ctrl
#(
   parameter bit MID_RESET = 1'b0
)
(
   // system
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // serial link
   input  wire logic        sclk,
   input  wire logic        frameSel_n,
   input  wire logic        sdin,
   // load and clear pins
   input  wire logic        output_load_n,
   input  wire logic        async_reset_code_load_n,
   // channel codes and clear mode flag
   output logic [15:0]      channel_a_output,
   output logic [15:0]      channel_b_output,
   output logic             clearMode
);
   localparam logic [15:0] RST_CODE =
      MID_RESET ? ddl_pkg::CODE_MID : ddl_pkg::CODE_ZERO;

   logic [23:0] frameWord;
   logic        frameDone;

   ddl_link_rx ddl_link_rx_inst
   (
      .sclk       (sclk),
      .frameSel_n (frameSel_n),
      .sdin       (sdin),
      .frameWord  (frameWord),
      .frameDone  (frameDone)
   );

   typedef struct packed
   {
      logic [1:0]  doneSy;
      logic        doneOld;
      logic [1:0]  ldSy;
      logic        ldOld;
      logic [1:0]  clrSy;
      logic        clrOld;
      logic [1:0]  selSy;
      logic        abortPend;
      logic [1:0][15:0] buf_;
      logic [1:0][15:0] out;
      logic        clrMode;
   } ddl_st_t;
   ddl_st_t st_ff, nxt_st;

   logic        frameEv;
   logic        ldFall;
   logic        clrFall;
   logic [3:0]  cmd;
   logic [3:0]  adr;
   logic [15:0] code;

   // events from second synchroniser stage only
   assign frameEv = st_ff.doneSy[1] & ~st_ff.doneOld;
   assign ldFall  = st_ff.ldOld & ~st_ff.ldSy[1];
   assign clrFall = st_ff.clrOld & ~st_ff.clrSy[1];
   assign cmd  = frameWord[ddl_pkg::CMD_HI:ddl_pkg::CMD_LO];
   assign adr  = frameWord[ddl_pkg::ADR_HI:ddl_pkg::ADR_LO];
   assign code = frameWord[ddl_pkg::CODE_BITS-1:0];

   // next state: clear beats frame and load; a load copies the buffers after the frame write
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.doneSy  = {st_ff.doneSy[0], frameDone};
      nxt_st.doneOld = st_ff.doneSy[1];
      nxt_st.ldSy   = {st_ff.ldSy[0], output_load_n};
      nxt_st.ldOld  = st_ff.ldSy[1];
      nxt_st.clrSy  = {st_ff.clrSy[0], async_reset_code_load_n};
      nxt_st.clrOld = st_ff.clrSy[1];
      nxt_st.selSy  = {st_ff.selSy[0], frameSel_n};
      // frame in flight when clear falls is marked for discard; only a
      // frame cut short by deselect (done still low) drops the mark here,
      // a finished one drops it at its own event, so no race with select
      if (st_ff.selSy[1] && !st_ff.doneSy[1])
         nxt_st.abortPend = 1'b0;
      if (clrFall)
      begin
         nxt_st.buf_ = {RST_CODE, RST_CODE};   // [R10]
         nxt_st.out  = {RST_CODE, RST_CODE};
         nxt_st.clrMode = 1'b1;
         nxt_st.abortPend = ~st_ff.selSy[1];   // [R12]
      end
      else
      begin
         if (frameEv && !st_ff.abortPend)      // [R03]
         begin
            for (int c = 0; c < 2; c++)        // [R13]
            begin
               if (adr == 4'(c) || adr == ddl_pkg::ADR_ALL)
               begin
                  nxt_st.buf_[c] = code;       // [R09]
                  // synchronous mode: load pin low at frame end
                  if (cmd == ddl_pkg::CMD_WR_UPD || !st_ff.ldSy[1])
                     nxt_st.out[c] = code;     // [R06]
               end
            end
            nxt_st.clrMode = 1'b0;             // [R11]
         end
         if (frameEv && st_ff.abortPend)
            nxt_st.abortPend = 1'b0;
         if (ldFall)
            nxt_st.out = nxt_st.buf_;          // [R08]
      end
   end

   // one register bank for all state
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         // done seen as old and high: no false frame event after reset
         st_ff.doneSy <= 2'h3;
         st_ff.doneOld <= 1'b1;
         st_ff.ldSy <= 2'h3;
         st_ff.ldOld <= 1'b1;
         st_ff.clrSy <= 2'h3;
         st_ff.clrOld <= 1'b1;
         st_ff.selSy <= 2'h3;
         st_ff.buf_ <= {RST_CODE, RST_CODE};
         st_ff.out <= {RST_CODE, RST_CODE};
         st_ff.clrMode <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign channel_a_output = st_ff.out[0];
   assign channel_b_output = st_ff.out[1];
   assign clearMode = st_ff.clrMode;

   a_clr_code: assert property (@(posedge mclk) disable iff (!rst_n)
      clrFall |=> st_ff.out[0] == RST_CODE && st_ff.out[1] == RST_CODE)
      else $error("clear did not load reset code"); // [R10]
   a_clr_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      clrFall |=> clearMode)
      else $error("clear mode not entered"); // [R11]
   a_load_both: assert property (@(posedge mclk) disable iff (!rst_n)
      ldFall && !clrFall && !frameEv |=> st_ff.out == $past(st_ff.buf_))
      else $error("load edge did not copy buffers"); // [R08]
   a_out_cause: assert property (@(posedge mclk) disable iff (!rst_n)
      !frameEv && !ldFall && !clrFall |=> $stable(st_ff.out))
      else $error("output moved without cause"); // [R03]
   a_abort_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      frameEv && st_ff.abortPend && !clrFall && !ldFall
      |=> $stable(st_ff.buf_))
      else $error("aborted frame applied"); // [R12]
   a_sync_upd: assert property (@(posedge mclk) disable iff (!rst_n)
      frameEv && !st_ff.abortPend && !clrFall && !st_ff.ldSy[1]
      && adr == ddl_pkg::ADR_A |=> channel_a_output == $past(code))
      else $error("synchronous update missing"); // [R06]
   a_buf_only: assert property (@(posedge mclk) disable iff (!rst_n)
      frameEv && !st_ff.abortPend && !clrFall && st_ff.ldSy[1]
      && !ldFall && cmd == ddl_pkg::CMD_WR_BUF && adr == ddl_pkg::ADR_B
      |=> $stable(channel_b_output) && st_ff.buf_[1] == $past(code))
      else $error("buffer write changed output"); // [R09]
   a_mode_exit: assert property (@(posedge mclk) disable iff (!rst_n)
      frameEv && !st_ff.abortPend && !clrFall |=> !clearMode)
      else $error("clear mode not left"); // [R11]
endmodule : ddl_load_ctrl
`default_nettype wire

/* File: verif/ddl_host_model.sv */
// host model: drives the three-wire serial port of the load block
// assumes the bench calls xfer one frame at a time
`default_nettype none
module ddl_host_model
(
   // serial port
   output logic sclk,
   output logic frameSel_n,
   output logic sdin
);
   timeunit 1ns;
   timeprecision 100ps;
   // clock idles high and stands still between frames
   initial
   begin
      sclk = 1'b1;
      frameSel_n = 1'b1;
      sdin = 1'b0;
   end
   // 15 ns period runs the shift clock at about 66.7 MHz, above the 50 MHz host limit
   task automatic xfer(input logic [23:0] w, input int nBits,
                       input int extra);
      frameSel_n = 1'b0;
      for (int i = 0; i < nBits + extra; i++)
      begin
         sdin = (i < 24) ? w[23 - i] : ~sdin;  // msb first, then junk
         #7.5 sclk = 1'b0;
         #7.5 sclk = 1'b1;
      end
      #7.5 frameSel_n = 1'b1;
      sdin = ~sdin;  // released line never shows a stale bit
   endtask : xfer
endmodule : ddl_host_model
`default_nettype wire

/* File: verif/dual_dac_serial_load_control_tb.sv */
// bench for the dual channel load block, scenario tasks and verdict
// assumes ddl_pkg and the host model are compiled first
`default_nettype none
module dual_dac_serial_load_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 1'b0;
   logic        rst_n, loadPin_n, clearPin_n, clearMode;
   logic [15:0] chA, chB;
   wire         sclk, frameSel_n, sdin;
   int          fail_count = 0;
   int          n_checks = 0;
   always #12.5 mclk = ~mclk;
   ddl_host_model ddl_host_model_inst (.sclk(sclk),
      .frameSel_n(frameSel_n), .sdin(sdin));
   ddl_load_ctrl ddl_load_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
      .sclk(sclk), .frameSel_n(frameSel_n), .sdin(sdin),
      .output_load_n(loadPin_n), .async_reset_code_load_n(clearPin_n),
      .channel_a_output(chA), .channel_b_output(chB),
      .clearMode(clearMode));
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : chk
   task automatic clk(input int n);
      repeat (n) @(negedge mclk);
   endtask : clk
   function automatic logic [23:0] mk(input logic [3:0] a,
                                      input logic [15:0] c);
      return {ddl_pkg::CMD_WR_BUF, a, c};
   endfunction : mk
   // n bits plus x extra edges, then settle past the 3 mclk edge answer
   task automatic send(input logic [3:0] a, input logic [15:0] c,
                       input int n, input int x);
      ddl_host_model_inst.xfer(mk(a, c), n, x);
      clk(8);
   endtask : send
   task automatic t_reset;
      chk(chA, ddl_pkg::CODE_ZERO, "reset a");
      chk({15'h0, clearMode}, 16'h0001, "reset mode");
   endtask : t_reset
   // load pin low: writes land straight on the outputs
   task automatic t_sync;
      loadPin_n = 1'b0;
      clk(6);
      send(ddl_pkg::ADR_A, 16'h1234, 24, 0);
      chk(chA, 16'h1234, "sync a");
      chk({15'h0, clearMode}, 16'h0000, "mode left");
      send(ddl_pkg::ADR_B, 16'h00ff, 20, 0);
      chk(chB, 16'h0000, "early deselect");
      send(ddl_pkg::ADR_B, 16'h4321, 24, 4);
      chk(chB, 16'h4321, "extra edges");
   endtask : t_sync
   // load pin high: buffers fill, one falling edge moves both
   task automatic t_async;
      loadPin_n = 1'b1;
      clk(6);
      send(ddl_pkg::ADR_A, 16'h5a5a, 24, 0);
      send(ddl_pkg::ADR_B, 16'ha5a5, 24, 0);
      chk(chA, 16'h1234, "held a");
      chk(chB, 16'h4321, "held b");
      loadPin_n = 1'b0;
      clk(6);
      chk(chA, 16'h5a5a, "load a");
      chk(chB, 16'ha5a5, "load b");
   endtask : t_async
   // clear lands mid-frame: that frame must not apply
   task automatic t_clear;
      fork
         ddl_host_model_inst.xfer(mk(ddl_pkg::ADR_A, 16'h7777), 24, 0);
         begin
            #150;
            @(negedge mclk) clearPin_n = 1'b0;
            clk(4);
            clearPin_n = 1'b1;
         end
      join
      clk(8);
      chk(chA, ddl_pkg::CODE_ZERO, "aborted a");
      chk(chB, ddl_pkg::CODE_ZERO, "cleared b");
      chk({15'h0, clearMode}, 16'h0001, "clear mode");
      send(ddl_pkg::ADR_B, 16'h0101, 24, 0);
      chk(chB, 16'h0101, "after clear");
      chk({15'h0, clearMode}, 16'h0000, "mode exit");
   endtask : t_clear
   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   // watchdog well past the few microseconds the tests need
   initial
   begin
      #100us;
      fail_count++;
      $display("CHECK FAILED %0t watchdog", $time);
      test_done();
   end
   initial
   begin
      rst_n = 1'b0;
      loadPin_n = 1'b1;
      clearPin_n = 1'b1;
      clk(4);
      rst_n = 1'b1;
      clk(2);
      t_reset();
      t_sync();
      t_async();
      t_clear();
      test_done();
   end
endmodule : dual_dac_serial_load_control_tb
`default_nettype wire
